/* File: include/lsu_pkg.sv */
// Constants and types shared by the load/store execution unit.
// Assumes a 32-bit big-endian data bus with per-byte write lanes.
package lsu_pkg;

  localparam int LSU_XLEN = 32;
  localparam int LSU_RADDR_W = 5;
  localparam int LSU_ASI_W = 8;
  localparam int LSU_IMM_W = 13;
  localparam int LSU_REG_ADDR_W = 4;
  localparam int LSU_CTRL_W = 3;

  // Second word of a pair sits one word above the first
  localparam logic [31:0] LSU_PAIR_STEP = 32'h0000_0004;

  // Access sizes
  localparam logic [1:0] LSU_SZ_BYTE = 2'h0;
  localparam logic [1:0] LSU_SZ_HALF = 2'h1;
  localparam logic [1:0] LSU_SZ_WORD = 2'h2;
  localparam logic [1:0] LSU_SZ_PAIR = 2'h3;

  // Write lane masks, lane 3 is the most significant byte
  localparam logic [3:0] LSU_MASK_WORD = 4'hf;
  localparam logic [3:0] LSU_MASK_HALF = 4'h3;
  localparam logic [3:0] LSU_MASK_BYTE = 4'h1;

  // Register port offsets
  localparam logic [3:0] LSU_REG_CTRL = 4'h0;
  localparam logic [3:0] LSU_REG_STATUS = 4'h4;
  localparam logic [3:0] LSU_REG_FAULT_ADDR = 4'h8;

  // Control register fields
  localparam int LSU_CTRL_FTT_CLR_BIT = 0;
  localparam int LSU_CTRL_ODD_INT_BIT = 1;
  localparam int LSU_CTRL_ODD_FP_BIT = 2;
  localparam logic [2:0] LSU_CTRL_RESET = 3'h7;

  // Status register fields
  localparam int LSU_STAT_TRAP_LSB = 0;
  localparam int LSU_STAT_BUSY_BIT = 3;
  localparam int LSU_STAT_CNT_LSB = 8;

  typedef enum logic [4:0] {
    LSU_OP_SBYTE_FETCH = 5'h00,
    LSU_OP_UBYTE_FETCH = 5'h01,
    LSU_OP_SHALF_FETCH = 5'h02,
    LSU_OP_UHALF_FETCH = 5'h03,
    LSU_OP_WORD_FETCH = 5'h04,
    LSU_OP_PAIR_FETCH = 5'h05,
    LSU_OP_BYTE_WRITE = 5'h06,
    LSU_OP_HALF_WRITE = 5'h07,
    LSU_OP_WORD_WRITE = 5'h08,
    LSU_OP_PAIR_WRITE = 5'h09,
    LSU_OP_FP_WORD_FETCH = 5'h0a,
    LSU_OP_FP_PAIR_FETCH = 5'h0b,
    LSU_OP_FP_STATE_FETCH = 5'h0c,
    LSU_OP_FP_WORD_WRITE = 5'h0d,
    LSU_OP_FP_PAIR_WRITE = 5'h0e,
    LSU_OP_FP_STATE_WRITE = 5'h0f,
    LSU_OP_FP_QUEUE_WRITE = 5'h10
  } lsu_op_t;

  typedef enum logic [2:0] {
    LSU_TRAP_NONE = 3'h0,
    LSU_TRAP_ILLEGAL = 3'h1,
    LSU_TRAP_PRIV = 3'h2,
    LSU_TRAP_FP_DISABLED = 3'h3,
    LSU_TRAP_FP_EXCEPTION = 3'h4,
    LSU_TRAP_MISALIGNED = 3'h5,
    LSU_TRAP_ACCESS_ERROR = 3'h6
  } lsu_trap_t;

  // Gray along idle, check, first access, second access, finish
  typedef enum logic [2:0] {
    LSU_S_IDLE = 3'b000,
    LSU_S_CHECK = 3'b001,
    LSU_S_ACC0 = 3'b011,
    LSU_S_ACC1 = 3'b010,
    LSU_S_FIN = 3'b110,
    LSU_S_WAIT = 3'b101
  } lsu_state_t;

endpackage

/* File: src/lsu_load_store_unit.sv */
// Load/store execution unit: address, space, checks, memory access, writeback.
// Assumes the issuing pipeline holds source values stable while busy_o is high,
// and that the data cache answers each request, after any number of wait states, with mem_ack_i.
//
// Notes on behaviour
// RULE1: narrow loads right-justified, sign or zero filled
// RULE2: pair load: even from ea, odd ea+4
// RULE3: pair load into r0 writes only r1
// RULE4: odd integer pair register may raise illegal_instruction
// RULE5: address is rs1 plus rs2 or immediate
// RULE6: alternate space from field, immediate form illegal
// RULE7: alternate forms need supervisor mode
// RULE8: plain forms use user or system space
// RULE9: integer loads checked for size alignment
// RULE10: integer stores checked for size alignment
// RULE11: stores write word, low half, or byte
// RULE12: pair store: even to ea, odd ea+4
// RULE13: fp word load and store move one word
// RULE14: fp pair ordered; odd register gives fp_exception
// RULE15: state load waits for fp operations
// RULE16: no forwarding of new condition codes
// RULE17: fp loads checked word or doubleword aligned
// RULE18: fp access traps when unit disabled or absent
// RULE19: state store waits, may clear trap type
// RULE20: fp stores checked word or doubleword aligned
// RULE21: queue store privileged, sequence error as fp_exception
// RULE22: trapped access changes no register or memory; a pair store that errs on its second word has already written the first
`timescale 1ns/100ps
`default_nettype none

module lsu_load_store_unit #(
  parameter logic [7:0] ASI_USER_DATA = 8'h0a,
  parameter logic [7:0] ASI_SUPV_DATA = 8'h0b,
  parameter logic [2:0] FTT_SEQUENCE = 3'h1,
  parameter logic [2:0] FTT_BAD_REG = 3'h2
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Issue
  input wire logic issue_i,
  input wire lsu_pkg::lsu_op_t op_i,
  input wire logic alt_i,
  input wire logic imm_sel_i,
  input wire logic [lsu_pkg::LSU_IMM_W-1:0] signed_imm_offset_i,
  input wire logic [lsu_pkg::LSU_ASI_W-1:0] asi_i,
  input wire logic [lsu_pkg::LSU_RADDR_W-1:0] rd_i,
  input wire logic [31:0] first_source_reg_i,
  input wire logic [31:0] second_source_reg_i,
  // Store sources
  input wire logic [31:0] int_src_even_i,
  input wire logic [31:0] int_src_odd_i,
  input wire logic [31:0] fp_src_even_i,
  input wire logic [31:0] fp_src_odd_i,
  input wire logic [31:0] fp_state_i,
  input wire logic [31:0] fq_addr_i,
  input wire logic [31:0] fq_instr_i,
  // Processor state
  input wire logic supervisor_i,
  input wire logic fp_enable_flag_i,
  input wire logic fpu_present_i,
  input wire logic fp_busy_i,
  input wire logic fq_present_i,
  input wire logic fq_not_empty_i,
  // Data cache
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [31:0] mem_addr_o,
  output logic [lsu_pkg::LSU_ASI_W-1:0] mem_asi_o,
  output logic [31:0] mem_wdata_o,
  output logic [3:0] mem_bmask_o,
  input wire logic mem_ack_i,
  input wire logic mem_err_i,
  input wire logic [31:0] mem_rdata_i,
  // Writeback
  output logic [1:0] wb_we_o,
  output logic wb_fp_o,
  output logic [lsu_pkg::LSU_RADDR_W-1:0] wb_addr0_o,
  output logic [lsu_pkg::LSU_RADDR_W-1:0] wb_addr1_o,
  output logic [31:0] wb_data0_o,
  output logic [31:0] wb_data1_o,
  output logic fsr_we_o,
  output logic [31:0] fsr_wdata_o,
  output logic ftt_clr_o,
  // Completion and traps
  output logic busy_o,
  output logic done_o,
  output logic trap_o,
  output lsu_pkg::lsu_trap_t trap_code_o,
  output logic [2:0] fp_trap_type_o,
  // Register port
  input wire logic [lsu_pkg::LSU_REG_ADDR_W-1:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o
);
  import lsu_pkg::*;

  function automatic logic [1:0] op_size(input lsu_op_t op);
    case (op)
      LSU_OP_SBYTE_FETCH, LSU_OP_UBYTE_FETCH, LSU_OP_BYTE_WRITE: op_size = LSU_SZ_BYTE;
      LSU_OP_SHALF_FETCH, LSU_OP_UHALF_FETCH, LSU_OP_HALF_WRITE: op_size = LSU_SZ_HALF;
      LSU_OP_PAIR_FETCH, LSU_OP_PAIR_WRITE, LSU_OP_FP_PAIR_FETCH, LSU_OP_FP_PAIR_WRITE,
      LSU_OP_FP_QUEUE_WRITE: op_size = LSU_SZ_PAIR;
      default: op_size = LSU_SZ_WORD;
    endcase
  endfunction
  // Big-endian lane pick with sign or zero fill
  function automatic logic [31:0] narrow_load(input lsu_op_t op, input logic [1:0] lane,
                                              input logic [31:0] d);
    logic [7:0] b;
    logic [15:0] h;
    b = d[8*(3-lane) +: 8];
    h = lane[1] ? d[15:0] : d[31:16];
    case (op)
      LSU_OP_SBYTE_FETCH: narrow_load = {{24{b[7]}}, b};
      LSU_OP_UBYTE_FETCH: narrow_load = {24'h00_0000, b};
      LSU_OP_SHALF_FETCH: narrow_load = {{16{h[15]}}, h};
      LSU_OP_UHALF_FETCH: narrow_load = {16'h0000, h};
      default: narrow_load = d;
    endcase
  endfunction
  lsu_state_t state_r;
  lsu_op_t op_q;
  logic alt_q;
  logic imm_q;
  logic [LSU_ASI_W-1:0] asi_q;
  logic [LSU_RADDR_W-1:0] rd_q;
  logic [31:0] ea_q;
  logic [31:0] buf0_r;
  logic [31:0] second_wdata_r;
  logic [LSU_CTRL_W-1:0] ctrl_r;
  lsu_trap_t last_trap_r;
  logic [7:0] trap_cnt_r;
  // RULE5: effective address
  wire [31:0] imm_ext_w = {{(32-LSU_IMM_W){signed_imm_offset_i[LSU_IMM_W-1]}},
                           signed_imm_offset_i};
  wire [31:0] ea_w = first_source_reg_i + (imm_sel_i ? imm_ext_w : second_source_reg_i);
  wire [1:0] size_w = op_size(op_q);
  wire is_int_pair_w = (op_q == LSU_OP_PAIR_FETCH) || (op_q == LSU_OP_PAIR_WRITE);
  wire is_fp_pair_w = (op_q == LSU_OP_FP_PAIR_FETCH) || (op_q == LSU_OP_FP_PAIR_WRITE);
  wire is_queue_w = (op_q == LSU_OP_FP_QUEUE_WRITE);
  wire is_fp_w = (op_q >= LSU_OP_FP_WORD_FETCH);
  wire is_state_w = (op_q == LSU_OP_FP_STATE_FETCH) || (op_q == LSU_OP_FP_STATE_WRITE);
  wire is_load_w = (op_q <= LSU_OP_PAIR_FETCH) || (op_q == LSU_OP_FP_WORD_FETCH) ||
                   (op_q == LSU_OP_FP_PAIR_FETCH) || (op_q == LSU_OP_FP_STATE_FETCH);
  // RULE9 RULE10 RULE17 RULE20: size alignment
  wire misalign_w = (size_w == LSU_SZ_HALF) ? ea_q[0] :
                    (size_w == LSU_SZ_WORD) ? (ea_q[1:0] != 2'h0) :
                    (size_w == LSU_SZ_PAIR) ? (ea_q[2:0] != 3'h0) : 1'b0;
  // RULE4 RULE6: odd pair, alternate immediate
  wire illegal_w = (alt_q && imm_q) || (alt_q && is_fp_w) ||
                   (is_int_pair_w && rd_q[0] && ctrl_r[LSU_CTRL_ODD_INT_BIT]);
  // RULE7 RULE21: privileged forms
  wire priv_w = (alt_q || is_queue_w) && !supervisor_i;
  // RULE18: fp unit disabled or absent
  wire fp_dis_w = is_fp_w && (!fp_enable_flag_i || !fpu_present_i);
  // RULE14 RULE21: odd fp pair, queue empty
  wire seq_err_w = is_queue_w && (!fq_present_i || !fq_not_empty_i);
  wire fp_exc_w = seq_err_w || (is_fp_pair_w && rd_q[0] && ctrl_r[LSU_CTRL_ODD_FP_BIT]);
  wire lsu_trap_t check_trap_w = illegal_w ? LSU_TRAP_ILLEGAL :
                                 priv_w ? LSU_TRAP_PRIV :
                                 fp_dis_w ? LSU_TRAP_FP_DISABLED :
                                 fp_exc_w ? LSU_TRAP_FP_EXCEPTION :
                                 misalign_w ? LSU_TRAP_MISALIGNED : LSU_TRAP_NONE;
  // RULE6 RULE8: space from field or mode
  wire [LSU_ASI_W-1:0] space_w = alt_q ? asi_q :
                                 (supervisor_i ? ASI_SUPV_DATA : ASI_USER_DATA);
  // RULE11: narrow data in every lane
  wire [31:0] int_wdata_w = (size_w == LSU_SZ_BYTE) ? {4{int_src_even_i[7:0]}} :
                            (size_w == LSU_SZ_HALF) ? {2{int_src_even_i[15:0]}} :
                            int_src_even_i;
  // RULE13: fp word source
  wire [31:0] first_wdata_w = is_queue_w ? fq_addr_i :
                              (op_q == LSU_OP_FP_STATE_WRITE) ? fp_state_i :
                              is_fp_w ? fp_src_even_i : int_wdata_w;
  wire [31:0] odd_wdata_w = is_queue_w ? fq_instr_i :
                            is_fp_w ? fp_src_odd_i : int_src_odd_i;
  wire [3:0] bmask_w = (size_w == LSU_SZ_BYTE) ? (LSU_MASK_BYTE << (2'h3 - ea_q[1:0])) :
                       (size_w == LSU_SZ_HALF) ? (ea_q[1] ? LSU_MASK_HALF :
                                                  4'(LSU_MASK_HALF << 2)) :
                       LSU_MASK_WORD;
  wire start_w = (state_r == LSU_S_CHECK && check_trap_w == LSU_TRAP_NONE &&
                  !(is_state_w && fp_busy_i)) ||
                 (state_r == LSU_S_WAIT && !fp_busy_i);
  wire acc_ok_w = mem_req_o && mem_ack_i && !mem_err_i;
  wire acc_err_w = mem_req_o && mem_ack_i && mem_err_i;
  wire [LSU_RADDR_W-1:0] even_rd_w = {rd_q[LSU_RADDR_W-1:1], 1'b0};
  wire [LSU_RADDR_W-1:0] odd_rd_w = {rd_q[LSU_RADDR_W-1:1], 1'b1};
  wire fin_load_w = (state_r == LSU_S_FIN) && is_load_w;
  // Instruction capture
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      op_q <= LSU_OP_SBYTE_FETCH;
      alt_q <= 1'b0;
      imm_q <= 1'b0;
      asi_q <= '0;
      rd_q <= '0;
      ea_q <= '0;
    end else if (issue_i && state_r == LSU_S_IDLE) begin
      op_q <= op_i;
      alt_q <= alt_i;
      imm_q <= imm_sel_i;
      asi_q <= asi_i;
      rd_q <= rd_i;
      ea_q <= ea_w;
    end
  end
  // Sequencer
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= LSU_S_IDLE;
    end else begin
      case (state_r)
        LSU_S_IDLE: if (issue_i) state_r <= LSU_S_CHECK;
        LSU_S_CHECK: begin
          if (check_trap_w != LSU_TRAP_NONE) state_r <= LSU_S_IDLE;
          // RULE15 RULE19: state access waits
          else if (is_state_w && fp_busy_i) state_r <= LSU_S_WAIT;
          else state_r <= LSU_S_ACC0;
        end
        LSU_S_WAIT: if (!fp_busy_i) state_r <= LSU_S_ACC0;
        LSU_S_ACC0: begin
          if (acc_err_w) state_r <= LSU_S_IDLE;
          else if (acc_ok_w) state_r <= (size_w == LSU_SZ_PAIR) ? LSU_S_ACC1 : LSU_S_FIN;
        end
        LSU_S_ACC1: begin
          if (acc_err_w) state_r <= LSU_S_IDLE;
          else if (acc_ok_w) state_r <= LSU_S_FIN;
        end
        LSU_S_FIN: state_r <= LSU_S_IDLE;
        default: state_r <= LSU_S_IDLE;
      endcase
    end
  end
  // Memory request, only after every check passed
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mem_req_o <= 1'b0;
      mem_we_o <= 1'b0;
      mem_addr_o <= '0;
      mem_asi_o <= '0;
      mem_wdata_o <= '0;
      mem_bmask_o <= '0;
      second_wdata_r <= '0;
    end else if (start_w) begin
      mem_req_o <= 1'b1;
      mem_we_o <= !is_load_w;
      mem_addr_o <= ea_q;
      mem_asi_o <= space_w;
      mem_wdata_o <= first_wdata_w;
      mem_bmask_o <= is_load_w ? LSU_MASK_WORD : bmask_w;
      second_wdata_r <= odd_wdata_w;
    end else if (acc_ok_w && state_r == LSU_S_ACC0 && size_w == LSU_SZ_PAIR) begin
      // RULE2 RULE12: odd word one step up
      mem_addr_o <= ea_q + LSU_PAIR_STEP;
      mem_wdata_o <= second_wdata_r;
    end else if (mem_ack_i) begin
      mem_req_o <= 1'b0;
      mem_we_o <= 1'b0;
    end
  end
  // RULE22: first word held until success
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) buf0_r <= '0;
    else if (acc_ok_w && state_r == LSU_S_ACC0) buf0_r <= mem_rdata_i;
  end
  // Writeback pulses
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wb_we_o <= 2'b00;
      wb_fp_o <= 1'b0;
      wb_addr0_o <= '0;
      wb_addr1_o <= '0;
      wb_data0_o <= '0;
      wb_data1_o <= '0;
      fsr_we_o <= 1'b0;
      fsr_wdata_o <= '0;
      ftt_clr_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      wb_we_o <= 2'b00;
      fsr_we_o <= 1'b0;
      ftt_clr_o <= 1'b0;
      done_o <= (state_r == LSU_S_FIN);
      // RULE2: odd word taken at its ack
      if (acc_ok_w && state_r == LSU_S_ACC1) wb_data1_o <= mem_rdata_i;
      if (fin_load_w && op_q != LSU_OP_FP_STATE_FETCH) begin
        wb_fp_o <= is_fp_w;
        if (size_w == LSU_SZ_PAIR) begin
          // RULE3 RULE14: even slot, odd slot
          wb_we_o <= {1'b1, is_fp_w || (even_rd_w != '0)};
          wb_addr0_o <= even_rd_w;
          wb_addr1_o <= odd_rd_w;
          wb_data0_o <= buf0_r;
        end else begin
          // RULE1 RULE13: justified, filled
          wb_we_o <= {1'b0, is_fp_w || (rd_q != '0)};
          wb_addr0_o <= rd_q;
          wb_data0_o <= narrow_load(op_q, ea_q[1:0], buf0_r);
        end
      end
      // RULE16: no forwarding to branches
      if (fin_load_w && op_q == LSU_OP_FP_STATE_FETCH) begin
        fsr_we_o <= 1'b1;
        fsr_wdata_o <= buf0_r;
      end
      // RULE19: trap type cleared after the store
      if (state_r == LSU_S_FIN && op_q == LSU_OP_FP_STATE_WRITE) begin
        ftt_clr_o <= ctrl_r[LSU_CTRL_FTT_CLR_BIT];
      end
    end
  end
  // Traps and status
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      trap_o <= 1'b0;
      trap_code_o <= LSU_TRAP_NONE;
      fp_trap_type_o <= '0;
      last_trap_r <= LSU_TRAP_NONE;
      trap_cnt_r <= '0;
      busy_o <= 1'b0;
    end else begin
      trap_o <= 1'b0;
      busy_o <= (state_r != LSU_S_IDLE) || issue_i;
      if (state_r == LSU_S_CHECK && check_trap_w != LSU_TRAP_NONE) begin
        trap_o <= 1'b1;
        trap_code_o <= check_trap_w;
        fp_trap_type_o <= seq_err_w ? FTT_SEQUENCE : FTT_BAD_REG;
        last_trap_r <= check_trap_w;
        trap_cnt_r <= trap_cnt_r + 8'h01;
      end else if (acc_err_w) begin
        trap_o <= 1'b1;
        trap_code_o <= LSU_TRAP_ACCESS_ERROR;
        last_trap_r <= LSU_TRAP_ACCESS_ERROR;
        trap_cnt_r <= trap_cnt_r + 8'h01;
      end
    end
  end
  // Register port: ctrl steers checks
  wire [31:0] status_w = ({28'h0, busy_o, last_trap_r} << LSU_STAT_TRAP_LSB) |
                         ({24'h0, trap_cnt_r} << LSU_STAT_CNT_LSB);
  wire [31:0] rd_mux_w = (reg_addr_i == LSU_REG_CTRL) ? {29'h0, ctrl_r} :
                         (reg_addr_i == LSU_REG_STATUS) ? status_w :
                         (reg_addr_i == LSU_REG_FAULT_ADDR) ? ea_q : 32'h0;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_r <= LSU_CTRL_RESET;
      reg_rdata_o <= '0;
    end else begin
      if (reg_wr_i && reg_addr_i == LSU_REG_CTRL) ctrl_r <= reg_wdata_i[LSU_CTRL_W-1:0];
      reg_rdata_o <= reg_rd_i ? rd_mux_w : 32'h0;
    end
  end
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_narrow_sign_fill: // RULE1
    assert property (wb_we_o[0] && op_q == LSU_OP_SBYTE_FETCH |->
                     wb_data0_o[31:8] == {24{wb_data0_o[7]}})
    else $error("signed byte load not sign filled");
  a_pair_order: // RULE2
    assert property (state_r == LSU_S_ACC1 && mem_req_o |-> mem_addr_o == ea_q + LSU_PAIR_STEP)
    else $error("bad second pair address");
  a_zero_reg_kept: // RULE3
    assert property (wb_we_o[0] && !wb_fp_o |-> wb_addr0_o != '0)
    else $error("write to hardwired zero register");
  a_ea_to_bus: // RULE5
    assert property (state_r == LSU_S_CHECK && start_w |=> mem_req_o && mem_addr_o == ea_q)
    else $error("access not at effective address");
  a_alt_imm_illegal: // RULE6
    assert property (state_r == LSU_S_CHECK && alt_q && imm_q |=>
                     trap_o && trap_code_o == LSU_TRAP_ILLEGAL && !mem_req_o)
    else $error("alt immediate not trapped");
  a_alt_privilege: // RULE7
    assert property (state_r == LSU_S_CHECK && alt_q && !illegal_w && !supervisor_i |=>
                     trap_o && trap_code_o == LSU_TRAP_PRIV)
    else $error("user alt access not trapped");
  a_fp_disabled: // RULE18
    assert property (state_r == LSU_S_CHECK && is_fp_w && !alt_q && !is_queue_w &&
                     !fp_enable_flag_i |=> trap_o && trap_code_o == LSU_TRAP_FP_DISABLED)
    else $error("disabled fp access not trapped");
  a_misalign_trap: // RULE9
    assert property (state_r == LSU_S_CHECK && misalign_w && !illegal_w && !priv_w &&
                     !fp_dis_w && !fp_exc_w |=> trap_code_o == LSU_TRAP_MISALIGNED ##1 !mem_req_o)
    else $error("misaligned access not trapped");
  sequence s_wait_busy;
    state_r == LSU_S_WAIT && fp_busy_i;
  endsequence
  a_state_waits: // RULE15
    assert property (s_wait_busy |=> state_r == LSU_S_WAIT && !mem_req_o)
    else $error("state access while fp busy");
  a_trap_no_write: // RULE22
    assert property (trap_o |-> wb_we_o == 2'b00 && !fsr_we_o ##1 wb_we_o == 2'b00)
    else $error("trapped access wrote register");

endmodule

`default_nettype wire

/* File: tb/lsu_mem_model.sv */
// Behavioural data cache for the load/store unit bench.
// Assumes 64 bytes of storage, the same in every space.
`timescale 1ns/100ps
`default_nettype none
module lsu_mem_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Request
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [31:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] bmask_i,
  // Wait states before each answer
  input wire logic [2:0] dly_i,
  // Answer
  output logic ack_o,
  output logic [31:0] rdata_o
);
  logic [31:0] mem_r [16];
  logic [2:0] cnt_r;
  wire logic [3:0] idx = addr_i[5:2];

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_o <= 1'b0;
      cnt_r <= 3'h0;
      rdata_o <= 32'h0;
    end else if (req_i && !ack_o && cnt_r == dly_i) begin
      ack_o <= 1'b1;
      cnt_r <= 3'h0;
      rdata_o <= mem_r[idx];
      for (int b = 0; b < 4; b++) begin
        if (we_i && bmask_i[b]) mem_r[idx][8*b +: 8] <= wdata_i[8*b +: 8];
      end
    end else begin
      ack_o <= 1'b0;
      cnt_r <= (req_i && !ack_o) ? cnt_r + 3'h1 : 3'h0;
      // Stale data must not look valid
      rdata_o <= ~rdata_o;
    end
  end
endmodule
`default_nettype wire

/* File: tb/lsu_load_store_unit_tb_top.sv */
// Bench for the load/store unit: issue and register tasks.
// Assumes the behavioural data cache model beside it.
`timescale 1ns/100ps
`default_nettype none
module lsu_load_store_unit_tb_top;
  import lsu_pkg::*;
  localparam logic [7:0] UASI = 8'h0a;
  localparam logic [7:0] SASI = 8'h0b;
  localparam logic [2:0] FSEQ = 3'h1;
  localparam logic [2:0] FBAD = 3'h2;
  logic clk_i, rst_n_i, issue_i, alt_i, imm_sel_i, supervisor_i, fp_enable_flag_i, fpu_present_i;
  logic fp_busy_i, fq_present_i, fq_not_empty_i, mem_ack_i, mem_err_i, reg_wr_i, reg_rd_i;
  logic mem_req_o, mem_we_o, wb_fp_o, fsr_we_o, ftt_clr_o, busy_o, done_o, trap_o, fw, fc;
  lsu_op_t op_i;
  lsu_trap_t trap_code_o, tr;
  logic [12:0] signed_imm_offset_i;
  logic [7:0] asi_i, mem_asi_o, lasi;
  logic [4:0] rd_i, wb_addr0_o, wb_addr1_o;
  logic [3:0] mem_bmask_o, reg_addr_i;
  logic [2:0] fp_trap_type_o, dly;
  logic [1:0] wb_we_o, we;
  logic [31:0] first_source_reg_i, second_source_reg_i, int_src_even_i, int_src_odd_i;
  logic [31:0] fp_src_even_i, fp_src_odd_i, fp_state_i, fq_addr_i, fq_instr_i, mem_addr_o;
  logic [31:0] mem_wdata_o, mem_rdata_i, wb_data0_o, wb_data1_o, fsr_wdata_o, reg_wdata_i;
  logic [31:0] reg_rdata_o, la, nacc;
  int n_fail, tests_run;

  lsu_load_store_unit #(.ASI_USER_DATA(UASI), .ASI_SUPV_DATA(SASI), .FTT_SEQUENCE(FSEQ),
    .FTT_BAD_REG(FBAD)) i_dut (.*);
  lsu_mem_model i_mem (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(mem_req_o), .we_i(mem_we_o),
    .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .bmask_i(mem_bmask_o), .dly_i(dly),
    .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    if (mem_req_o && mem_ack_i) begin
      la <= mem_addr_o;
      lasi <= mem_asi_o;
      nacc <= nacc + 32'h1;
    end
  end

  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] v);
    tests_run++;
    if (v !== x) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, x, v);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic t(input lsu_op_t o, input logic [31:0] ea, input logic [4:0] r,
      input lsu_trap_t x);
    logic [31:0] n0;
    int n;
    do @(posedge clk_i); while (busy_o);
    n0 = nacc;
    op_i <= o;
    rd_i <= r;
    first_source_reg_i <= imm_sel_i ? ea + 32'h4 : ea - 32'h8;
    issue_i <= 1'b1;
    @(posedge clk_i);
    issue_i <= 1'b0;
    #1;
    for (n = 0; n < 60 && done_o !== 1'b1 && trap_o !== 1'b1; n++) begin
      @(posedge clk_i);
      #1;
    end
    tr = (trap_o === 1'b1) ? trap_code_o : LSU_TRAP_NONE;
    we = wb_we_o;
    fw = fsr_we_o;
    fc = ftt_clr_o;
    chk("finished", 32'h1, 32'(done_o | trap_o));
    chk("trap", 32'(x), 32'(tr));
    if (x != LSU_TRAP_NONE) begin
      chk("accesses", n0, nacc);
      chk("wb_we", 32'h0, 32'(we));
    end
  endtask

  task automatic ld(input lsu_op_t o, input logic [31:0] ea, input logic [31:0] v);
    t(o, ea, 5'h5, LSU_TRAP_NONE);
    chk("wb_we", 32'h1, 32'(we));
    chk("wb_data0", v, wb_data0_o);
  endtask

  // Issue with fp work pending for 8 cycles
  task automatic held(input lsu_op_t o, input logic [31:0] ea);
    logic [31:0] nb;
    nb = nacc;
    fp_busy_i <= 1'b1;
    fork
      t(o, ea, 5'h0, LSU_TRAP_NONE);
      begin
        repeat (8) @(posedge clk_i);
        chk("held", nb, nacc);
        fp_busy_i <= 1'b0;
      end
    join
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 chk("reg_rdata", v, reg_rdata_o);
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    end_sim();
  end

  initial begin
    {issue_i, alt_i, reg_wr_i, reg_rd_i, fp_busy_i, supervisor_i, mem_err_i} = 7'h0;
    {fp_enable_flag_i, fpu_present_i, fq_present_i, fq_not_empty_i, imm_sel_i} = 5'h1f;
    {first_source_reg_i, second_source_reg_i, int_src_even_i, int_src_odd_i} = {32'h0, 32'h8, 64'h0};
    {fp_src_even_i, fp_src_odd_i, fp_state_i, fq_addr_i, fq_instr_i} = 160'h0;
    op_i = LSU_OP_WORD_FETCH;
    {signed_imm_offset_i, asi_i, rd_i} = {13'h1ffc, 13'h0};
    {reg_addr_i, reg_wdata_i, dly, nacc, n_fail, tests_run, rst_n_i} = '0;
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rr(LSU_REG_CTRL, 32'h7);
    int_src_even_i <= 32'h8091a2b3;
    t(LSU_OP_WORD_WRITE, 32'h10, 5'h4, LSU_TRAP_NONE);
    chk("asi", 32'(UASI), 32'(lasi));
    ld(LSU_OP_SBYTE_FETCH, 32'h10, 32'hffffff80);
    ld(LSU_OP_UBYTE_FETCH, 32'h11, 32'h91);
    imm_sel_i <= 1'b0;
    ld(LSU_OP_SHALF_FETCH, 32'h12, 32'hffffa2b3);
    ld(LSU_OP_UHALF_FETCH, 32'h10, 32'h8091);
    int_src_even_i <= 32'h55;
    t(LSU_OP_BYTE_WRITE, 32'h13, 5'h4, LSU_TRAP_NONE);
    int_src_even_i <= 32'h1234;
    t(LSU_OP_HALF_WRITE, 32'h10, 5'h4, LSU_TRAP_NONE);
    ld(LSU_OP_WORD_FETCH, 32'h10, 32'h1234a255);
    dly <= 3'h3;
    int_src_even_i <= 32'haaaa0001;
    int_src_odd_i <= 32'hbbbb0002;
    t(LSU_OP_PAIR_WRITE, 32'h18, 5'h4, LSU_TRAP_NONE);
    chk("last addr", 32'h1c, la);
    t(LSU_OP_PAIR_FETCH, 32'h18, 5'h0, LSU_TRAP_NONE);
    chk("wb_we", 32'h2, 32'(we));
    chk("wb_addr1", 32'h1, 32'(wb_addr1_o));
    t(LSU_OP_PAIR_FETCH, 32'h18, 5'h6, LSU_TRAP_NONE);
    chk("wb_data0", 32'haaaa0001, wb_data0_o);
    chk("wb_data1", 32'hbbbb0002, wb_data1_o);
    dly <= 3'h0;
    t(LSU_OP_WORD_FETCH, 32'h12, 5'h5, LSU_TRAP_MISALIGNED);
    t(LSU_OP_PAIR_FETCH, 32'h14, 5'h6, LSU_TRAP_MISALIGNED);
    t(LSU_OP_HALF_WRITE, 32'h11, 5'h4, LSU_TRAP_MISALIGNED);
    t(LSU_OP_PAIR_WRITE, 32'h1c, 5'h4, LSU_TRAP_MISALIGNED);
    t(LSU_OP_PAIR_FETCH, 32'h18, 5'h3, LSU_TRAP_ILLEGAL);
    wr(LSU_REG_CTRL, 32'h0);
    t(LSU_OP_PAIR_WRITE, 32'h18, 5'h3, LSU_TRAP_NONE);
    wr(LSU_REG_CTRL, 32'h7);
    alt_i <= 1'b1;
    imm_sel_i <= 1'b1;
    t(LSU_OP_WORD_FETCH, 32'h10, 5'h5, LSU_TRAP_ILLEGAL);
    imm_sel_i <= 1'b0;
    t(LSU_OP_WORD_WRITE, 32'h10, 5'h5, LSU_TRAP_PRIV);
    supervisor_i <= 1'b1;
    asi_i <= 8'h33;
    t(LSU_OP_WORD_FETCH, 32'h10, 5'h5, LSU_TRAP_NONE);
    chk("asi", 32'h33, 32'(lasi));
    alt_i <= 1'b0;
    ld(LSU_OP_UBYTE_FETCH, 32'h13, 32'h55);
    chk("asi", 32'(SASI), 32'(lasi));
    fp_enable_flag_i <= 1'b0;
    t(LSU_OP_FP_WORD_WRITE, 32'h20, 5'h2, LSU_TRAP_FP_DISABLED);
    fp_enable_flag_i <= 1'b1;
    fpu_present_i <= 1'b0;
    t(LSU_OP_FP_PAIR_FETCH, 32'h20, 5'h2, LSU_TRAP_FP_DISABLED);
    fpu_present_i <= 1'b1;
    fp_src_even_i <= 32'hc0de0001;
    fp_src_odd_i <= 32'hc0de0002;
    t(LSU_OP_FP_WORD_WRITE, 32'h20, 5'h2, LSU_TRAP_NONE);
    ld(LSU_OP_FP_WORD_FETCH, 32'h20, 32'hc0de0001);
    chk("wb_fp", 32'h1, 32'(wb_fp_o));
    t(LSU_OP_FP_PAIR_WRITE, 32'h28, 5'h2, LSU_TRAP_NONE);
    t(LSU_OP_FP_PAIR_FETCH, 32'h28, 5'h4, LSU_TRAP_NONE);
    chk("wb_data1", 32'hc0de0002, wb_data1_o);
    t(LSU_OP_FP_PAIR_FETCH, 32'h28, 5'h5, LSU_TRAP_FP_EXCEPTION);
    chk("ftt", 32'(FBAD), 32'(fp_trap_type_o));
    t(LSU_OP_FP_PAIR_WRITE, 32'h2c, 5'h2, LSU_TRAP_MISALIGNED);
    t(LSU_OP_FP_PAIR_FETCH, 32'h24, 5'h4, LSU_TRAP_MISALIGNED);
    t(LSU_OP_FP_STATE_FETCH, 32'h22, 5'h0, LSU_TRAP_MISALIGNED);
    held(LSU_OP_FP_STATE_FETCH, 32'h20);
    chk("fsr_we", 32'h1, 32'(fw));
    chk("fsr_wdata", 32'hc0de0001, fsr_wdata_o);
    fp_state_i <= 32'h5a5a0003;
    held(LSU_OP_FP_STATE_WRITE, 32'h24);
    chk("ftt_clr", 32'h1, 32'(fc));
    ld(LSU_OP_WORD_FETCH, 32'h24, 32'h5a5a0003);
    supervisor_i <= 1'b0;
    t(LSU_OP_FP_QUEUE_WRITE, 32'h30, 5'h0, LSU_TRAP_PRIV);
    supervisor_i <= 1'b1;
    fq_not_empty_i <= 1'b0;
    t(LSU_OP_FP_QUEUE_WRITE, 32'h30, 5'h0, LSU_TRAP_FP_EXCEPTION);
    chk("ftt", 32'(FSEQ), 32'(fp_trap_type_o));
    fq_not_empty_i <= 1'b1;
    fq_addr_i <= 32'h100;
    t(LSU_OP_FP_QUEUE_WRITE, 32'h34, 5'h0, LSU_TRAP_MISALIGNED);
    t(LSU_OP_FP_QUEUE_WRITE, 32'h30, 5'h0, LSU_TRAP_NONE);
    rr(LSU_REG_FAULT_ADDR, 32'h30);
    rr(4'hc, 32'h0);
    end_sim();
  end
endmodule
`default_nettype wire
